//--- design/iam_pkg.sv
// package: constants, types and register map of the interrupt accept unit
package iam_pkg;
	// axi4-lite register byte offsets
	localparam logic [7:0] CTRL_OFF     = 8'h00; // control: enable flag, privilege
	localparam logic [7:0] STATUS_OFF   = 8'h04; // status: blocking, window, flags
	localparam logic [7:0] DISPATCH_OFF = 8'h08; // last dispatch record
	// control field positions
	localparam int CTRL_IF_BIT   = 0;
	localparam int CTRL_RF_BIT   = 1;
	localparam int CTRL_CPL_LSB  = 4;
	localparam int CTRL_IO_PRIVILEGE_LEVEL_LSB = 6;
	// status field positions
	localparam int ST_IF_BIT    = 0;
	localparam int ST_NMIBLK_BIT = 1;
	localparam int ST_SSWIN_BIT = 2;
	localparam int ST_RF_BIT    = 3;
	localparam int ST_GPCNT_LSB = 8;
	// fixed vectors and ranges
	localparam logic [7:0] NMI_VECTOR     = 8'h02;
	localparam logic [7:0] PIN_VEC_MAX    = 8'h20;
	localparam logic [7:0] LIC_VEC_MIN    = 8'h10;
	localparam logic [7:0] LIC_VEC_MAX    = 8'h20;
	localparam logic [1:0] IO_PRIVILEGE_LEVEL_V86_FULL  = 2'h3;
	// reset value and axi response codes
	localparam logic       IF_RESET   = 1'b0;
	localparam logic [1:0] RESP_OKAY  = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// dispatch kind codes
	typedef enum logic [2:0] {
		DK_NONE  = 3'b000,
		DK_NMI   = 3'b001,
		DK_PIN   = 3'b010,
		DK_LIC   = 3'b011,
		DK_DEBUG = 3'b100,
		DK_GP    = 3'b101
	} iam_kind_t;
endpackage

//--- design/iam_accept.sv
// interrupt accept and mask logic with axi4-lite register access
// What this block does
// - nmi from pin or bus message
// - true nmi dispatches to vector 2 at a boundary
// - enable flag never gates nmi
// - pin vector 2 never engages nmi blocking
// - block further nmi until next return_from_interrupt
// - v86 low-privilege return releases blocking before fault
// - enable flag clear gates pin and controller requests
// - enable flag does not gate processor exceptions
// - reset clears the enable flag
// - accept pin 0..32, controller 16..32 vectors
// - maskable exception vector pushes no error code
// - set/clear enable only if cpl <= io_privilege_level
// - flags reload paths update enable flag
// - interrupt gate clears enable on nmi and maskable dispatch, trap gate keeps
// - resume flag suppresses instruction-breakpoint debug
// - stack segment move inhibits for one instruction
// - take interrupts only at instruction boundaries
// - nmi outranks maskable; pending kept, exceptions dropped
`timescale 1ns/1ns
`default_nettype none
module iam_accept
	import iam_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// request sources
	input  wire logic        nmiPin,          // dedicated non-maskable pin
	input  wire logic        nmiMessage,      // bus message, nmi delivery
	input  wire logic        maskableRequestPin,
	input  wire logic [7:0]  pinVector,
	input  wire logic        licRequest,      // local interrupt controller
	input  wire logic [7:0]  licVector,
	input  wire logic        coreException,   // processor generated
	input  wire logic [7:0]  coreExcVector,
	input  wire logic        breakpointMatch, // instruction breakpoint
	input  wire logic        singleStepTrap,
	// instruction retirement events
	input  wire logic        boundary,        // instruction boundary
	input  wire logic        setEnableInstr,
	input  wire logic        clearEnableInstr,
	input  wire logic        flagsLoad,       // pop, return_from_interrupt or task switch
	input  wire logic        flagsLoadIf,     // enable bit being loaded
	input  wire logic        returnFromInterrupt,
	input  wire logic        v86Handler,      // handler is a v86 task
	input  wire logic        stackSegmentMove,
	input  wire logic        gateIsTrap,      // gate type of dispatch
	// dispatch outputs
	output var  logic        dispatchValid,
	output var  logic [7:0]  dispatchVector,
	output var  logic [2:0]  dispatchKind,
	output var  logic        dispatchErrCode, // push an error code
	output var  logic        enableFlag,
	output var  logic        flagsPushBit     // enable bit for flags push
);
	// whole state of the block
	typedef struct packed {
		logic        rst1;
		logic        rst2;
		logic        ifFlag;
		logic        rf;
		logic [1:0]  current_privilege_level;
		logic [1:0]  io_privilege_level;
		logic        nmiBlock;
		logic        nmiPend;
		logic        ssWin;    // inhibit window armed
		logic [7:0]  gpCount;
		logic        awDone;
		logic        wDone;
		logic [7:0]  awAddr;
		logic [31:0] wData;
		logic [3:0]  wStrb;
		logic        bValid;
		logic [1:0]  bResp;
		logic        rValid;
		logic [31:0] rData;
		logic [1:0]  rResp;
		// registered readies for the three request channels
		logic        awRdy;    // write address ready
		logic        wRdy;     // write data ready
		logic        arRdy;    // read address ready
		logic        dValid;
		logic [7:0]  dVec;
		logic [2:0]  dKind;
		logic        dErr;
	} iam_state_t;

	iam_state_t st_r;
	iam_state_t st_nxt;

	// exception vectors that push an error code when truly raised
	function automatic logic hasErrCode(input logic [7:0] v);
		hasErrCode = (v == 8'h08) || (v >= 8'h0A && v <= 8'h0E) ||
			(v == 8'h11);
	endfunction

	// status word for reads
	function automatic logic [31:0] statusWord(input iam_state_t s);
		statusWord = 32'h0000_0000;
		statusWord[ST_IF_BIT] = s.ifFlag;
		statusWord[ST_NMIBLK_BIT] = s.nmiBlock;
		statusWord[ST_SSWIN_BIT] = s.ssWin;
		statusWord[ST_RF_BIT] = s.rf;
		statusWord[ST_GPCNT_LSB +: 8] = s.gpCount;
	endfunction

	logic rstn;
	assign rstn = st_r.rst2;

	logic pinOk;
	logic licOk;
	logic inhibit;
	logic gpOnCli;
	logic wrFire;

	// next-state logic
	always_comb begin
		st_nxt = st_r;
		st_nxt.rst1 = 1'b1;
		st_nxt.rst2 = st_r.rst1;
		pinOk = maskableRequestPin && pinVector <= PIN_VEC_MAX;
		licOk = licRequest && licVector >= LIC_VEC_MIN &&
			licVector <= LIC_VEC_MAX;
		inhibit = st_r.ssWin;
		gpOnCli = st_r.current_privilege_level > st_r.io_privilege_level;
		st_nxt.dValid = 1'b0;
		// a true nmi latches regardless of the enable flag
		if (nmiPin || nmiMessage) begin
			st_nxt.nmiPend = 1'b1;
		end
		// enable flag updates from instructions
		if (setEnableInstr || clearEnableInstr) begin
			if (!gpOnCli) begin
				st_nxt.ifFlag = setEnableInstr;
			end else begin
				st_nxt.gpCount = st_r.gpCount + 8'h01;
			end
		end
		if (flagsLoad) begin
			st_nxt.ifFlag = flagsLoadIf;
		end
		// return ends nmi blocking; v86 fault case unmasks first too
		if (returnFromInterrupt) begin
			st_nxt.nmiBlock = 1'b0;
			if (v86Handler && st_r.io_privilege_level < IO_PRIVILEGE_LEVEL_V86_FULL) begin
				st_nxt.gpCount = st_nxt.gpCount + 8'h01;
				st_nxt.dValid = 1'b1;
				st_nxt.dVec = 8'h0D;
				st_nxt.dKind = DK_GP;
				st_nxt.dErr = 1'b1;
			end
		end
		// dispatch only at a boundary
		if (boundary) begin
			st_nxt.ssWin = stackSegmentMove;
			if (coreException) begin
				// exceptions ignore the enable flag
				st_nxt.dValid = 1'b1;
				st_nxt.dVec = coreExcVector;
				st_nxt.dKind = DK_NONE;
				st_nxt.dErr = hasErrCode(coreExcVector);
			end else if (!inhibit && breakpointMatch && !st_r.rf) begin
				st_nxt.dValid = 1'b1;
				st_nxt.dVec = 8'h01;
				st_nxt.dKind = DK_DEBUG;
				st_nxt.dErr = 1'b0;
			end else if (!inhibit && singleStepTrap) begin
				st_nxt.dValid = 1'b1;
				st_nxt.dVec = 8'h01;
				st_nxt.dKind = DK_DEBUG;
				st_nxt.dErr = 1'b0;
			end else if (!inhibit && st_r.nmiPend && !st_r.nmiBlock) begin
				st_nxt.dValid = 1'b1;
				st_nxt.dVec = NMI_VECTOR;
				st_nxt.dKind = DK_NMI;
				st_nxt.dErr = 1'b0;
				st_nxt.nmiPend = nmiPin || nmiMessage;
				st_nxt.nmiBlock = 1'b1;
				if (!gateIsTrap) begin
					st_nxt.ifFlag = 1'b0;
				end
			end else if (!inhibit && st_r.ifFlag && (pinOk || licOk)) begin
				st_nxt.dValid = 1'b1;
				st_nxt.dVec = pinOk ? pinVector : licVector;
				st_nxt.dKind = pinOk ? DK_PIN : DK_LIC;
				st_nxt.dErr = 1'b0;
				if (!gateIsTrap) begin
					st_nxt.ifFlag = 1'b0;
				end
			end
		end
		// axi write channel, address and data in either order
		// an item is only taken while its registered ready stands
		if (s_axi_awvalid && st_r.awRdy) begin
			st_nxt.awDone = 1'b1;
			st_nxt.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_r.wRdy) begin
			st_nxt.wDone = 1'b1;
			st_nxt.wData = s_axi_wdata;
			st_nxt.wStrb = s_axi_wstrb;
		end
		wrFire = st_r.awDone && st_r.wDone && !st_r.bValid;
		if (wrFire) begin
			st_nxt.awDone = 1'b0;
			st_nxt.wDone = 1'b0;
			st_nxt.bValid = 1'b1;
			if (st_r.awAddr == CTRL_OFF) begin
				st_nxt.bResp = RESP_OKAY;
				if (st_r.wStrb[0]) begin
					st_nxt.ifFlag = st_r.wData[CTRL_IF_BIT];
					st_nxt.rf = st_r.wData[CTRL_RF_BIT];
					st_nxt.current_privilege_level = st_r.wData[CTRL_CPL_LSB +: 2];
					st_nxt.io_privilege_level = st_r.wData[CTRL_IO_PRIVILEGE_LEVEL_LSB +: 2];
				end
			end else if (st_r.awAddr == STATUS_OFF ||
				st_r.awAddr == DISPATCH_OFF) begin
				st_nxt.bResp = RESP_OKAY; // read-only, write ignored
			end else begin
				st_nxt.bResp = RESP_SLVERR;
			end
		end
		if (st_r.bValid && s_axi_bready) begin
			st_nxt.bValid = 1'b0;
		end
		// axi read channel
		// a new read waits until the last one has been handed back
		if (s_axi_arvalid && st_r.arRdy) begin
			st_nxt.rValid = 1'b1;
			st_nxt.rResp = RESP_OKAY;
			if (s_axi_araddr == CTRL_OFF) begin
				st_nxt.rData = {24'h000000, st_r.io_privilege_level, st_r.current_privilege_level, 2'b00,
					st_r.rf, st_r.ifFlag};
			end else if (s_axi_araddr == STATUS_OFF) begin
				st_nxt.rData = statusWord(st_r);
			end else if (s_axi_araddr == DISPATCH_OFF) begin
				st_nxt.rData = {20'h00000, st_r.dErr, st_r.dKind, st_r.dVec};
			end else begin
				st_nxt.rData = 32'h0000_0000;
				st_nxt.rResp = RESP_SLVERR;
			end
		end else if (st_r.rValid && s_axi_rready) begin
			st_nxt.rValid = 1'b0;
		end
		// readies are flops; each falls at the edge its item is taken
		st_nxt.awRdy = !st_nxt.awDone;
		st_nxt.wRdy = !st_nxt.wDone;
		st_nxt.arRdy = !st_nxt.rValid;
		// hold everything but the synchroniser in reset
		if (!rstn) begin
			st_nxt = '0;
			st_nxt.rst1 = 1'b1;
			st_nxt.rst2 = st_r.rst1;
			st_nxt.ifFlag = IF_RESET;
		end
	end

	// single state register; async reset only loads constants
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state flops
	// readies carry no gate in front of the port, so they cannot glitch
	// readies stay low until the internal reset copy has gone high
	assign s_axi_awready = st_r.awRdy;
	assign s_axi_wready = st_r.wRdy;
	assign s_axi_bvalid = st_r.bValid;
	assign s_axi_bresp = st_r.bResp;
	assign s_axi_arready = st_r.arRdy;
	assign s_axi_rvalid = st_r.rValid;
	assign s_axi_rdata = st_r.rData;
	assign s_axi_rresp = st_r.rResp;
	assign dispatchValid = st_r.dValid;
	assign dispatchVector = st_r.dVec;
	assign dispatchKind = st_r.dKind;
	assign dispatchErrCode = st_r.dErr;
	assign enableFlag = st_r.ifFlag;
	assign flagsPushBit = st_r.ifFlag;
endmodule // iam_accept
`default_nettype wire

//--- testbench/iam_accept_checker.sv
// port-level assertions for the interrupt accept unit
`timescale 1ns/1ns
`default_nettype none
module iam_accept_checker
	import iam_pkg::*;
(
	input wire logic       clock,
	input wire logic       resetn,
	input wire logic       boundary,
	input wire logic       stackSegmentMove,
	input wire logic       returnFromInterrupt,
	input wire logic       gateIsTrap,
	input wire logic       dispatchValid,
	input wire logic [7:0] dispatchVector,
	input wire logic [2:0] dispatchKind,
	input wire logic       dispatchErrCode,
	input wire logic       enableFlag
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	logic ssWin_r, blk_r, nmiDisp, mask, blkNow; // shadows of hidden state
	assign nmiDisp = dispatchValid && dispatchKind == DK_NMI;
	assign mask = dispatchValid && dispatchKind inside {DK_PIN, DK_LIC};
	assign blkNow = blk_r || nmiDisp;
	// rebuilt from ports only, so a wrong internal copy cannot hide
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ssWin_r <= 1'h0;
			blk_r <= 1'h0;
		end else begin
			if (boundary)
				ssWin_r <= stackSegmentMove;
			blk_r <= blkNow && !returnFromInterrupt;
		end
	end
	property p_bnd; dispatchValid && dispatchKind != DK_GP |->
		$past(boundary); endproperty
	a_bnd: assert property (p_bnd) else $error("off boundary");
	property p_nmiv; nmiDisp |-> dispatchVector == NMI_VECTOR; endproperty
	a_nmiv: assert property (p_nmiv) else $error("nmi vector");
	property p_pinv; dispatchValid && dispatchKind == DK_PIN |->
		dispatchVector <= PIN_VEC_MAX; endproperty
	a_pinv: assert property (p_pinv) else $error("pin range");
	property p_licv; dispatchValid && dispatchKind == DK_LIC |->
		dispatchVector inside {[LIC_VEC_MIN:LIC_VEC_MAX]}; endproperty
	a_licv: assert property (p_licv) else $error("ctl range");
	property p_noerr; mask |-> !dispatchErrCode; endproperty
	a_noerr: assert property (p_noerr) else $error("err code");
	property p_ifg; mask |-> $past(enableFlag); endproperty
	a_ifg: assert property (p_ifg) else $error("masked taken");
	property p_gate; mask && !$past(gateIsTrap) |-> !enableFlag; endproperty
	a_gate: assert property (p_gate) else $error("gate flag");
	property p_nest; nmiDisp |-> !$past(blkNow) ||
		$past(returnFromInterrupt); endproperty
	a_nest: assert property (p_nest) else $error("nested nmi");
	property p_ss; boundary && ssWin_r |=> !(dispatchValid &&
		dispatchKind inside {DK_NMI, DK_PIN, DK_LIC, DK_DEBUG}); endproperty
	a_ss: assert property (p_ss) else $error("ss window");
	property p_rst; disable iff (1'h0) !resetn |=> !enableFlag; endproperty
	a_rst: assert property (p_rst) else $error("reset flag");
	c_nmi: cover property (nmiDisp);
	c_mask: cover property (mask);
	c_ss: cover property (boundary && ssWin_r);
	c_gp: cover property (dispatchValid && dispatchKind == DK_GP);
endmodule // iam_accept_checker
bind iam_accept iam_accept_checker chk (.*);
`default_nettype wire

//--- testbench/iam_source_model.sv
// far side: nmi pin, nmi message, request pin and local controller
`timescale 1ns/1ns
`default_nettype none
module iam_source_model
	import iam_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       srcGo,   // start one request
	input  wire logic       srcDrop, // withdraw level requests
	input  wire logic [1:0] srcSel,  // 0 pin, 1 message, 2 req pin, 3 ctl
	input  wire logic [7:0] srcVec,
	input  wire logic       dispatchValid,
	input  wire logic [2:0] dispatchKind,
	output var  logic       nmiPin,
	output var  logic       nmiMessage,
	output var  logic       maskableRequestPin,
	output var  logic [7:0] pinVector,
	output var  logic       licRequest,
	output var  logic [7:0] licVector
);
	logic done; // request served or withdrawn
	assign done = srcDrop || dispatchValid &&
		dispatchKind inside {DK_PIN, DK_LIC};
	// nmi is a one-cycle pulse; maskable lines hold until served or withdrawn
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			{nmiPin, nmiMessage, maskableRequestPin, licRequest} <= 4'h0;
			pinVector <= 8'h00;
			licVector <= 8'h00;
		end else begin
			nmiPin <= srcGo && srcSel == 2'h0;
			nmiMessage <= srcGo && srcSel == 2'h1;
			if (srcGo && srcSel[1]) begin
				maskableRequestPin <= !srcSel[0];
				licRequest <= srcSel[0];
				pinVector <= srcVec;
				licVector <= srcVec;
			end else if (done) begin
				// released lines must not keep a stale vector
				maskableRequestPin <= 1'h0;
				licRequest <= 1'h0;
				pinVector <= ~pinVector;
				licVector <= ~licVector;
			end
		end
	end
endmodule // iam_source_model
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the interrupt accept unit
`timescale 1ns/1ns
`default_nettype none
module tb;
	import iam_pkg::*;
	logic clock = '0, resetn = '0, srcGo = '0, srcDrop = '0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, srcVec = '0;
	logic [7:0] coreExcVector = '0, pinVector, licVector, dispatchVector;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, srcSel = '0;
	logic [2:0] dispatchKind;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic nmiPin, nmiMessage, maskableRequestPin, licRequest;
	logic dispatchValid, dispatchErrCode, enableFlag, flagsPushBit;
	logic coreException = '0, breakpointMatch = '0, singleStepTrap = '0;
	logic boundary = '0, setEnableInstr = '0, clearEnableInstr = '0;
	logic flagsLoad = '0, flagsLoadIf = '0, returnFromInterrupt = '0;
	logic v86Handler = '0, stackSegmentMove = '0, gateIsTrap = '0;
	int failures = 0, samples_checked = 0, cyc = 0;
	iam_accept uut (.*);
	iam_source_model src (.*);
	always #50 clock = ~clock;
	task stop_test;
		if (failures == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard: far above the under two hundred cycles the run needs
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			stop_test;
		end
	end
	task automatic check(input string n, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		check("bresp", 32'(s_axi_bresp), 32'(RESP_OKAY));
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, r);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		// rready stays up between reads, never dropped and raised at once
		d = s_axi_rdata;
		r = 32'(s_axi_rresp);
	endtask
	task automatic go(input logic [1:0] s, input logic [7:0] v);
		{srcSel, srcVec, srcGo} <= {s, v, 1'h1};
		@(posedge clock);
		srcGo <= 1'h0;
		@(posedge clock);
	endtask
	// one boundary, then the registered dispatch a cycle later
	task automatic ex(input logic v, input logic [2:0] k, input logic [7:0] e);
		boundary <= 1'h1;
		@(posedge clock);
		{boundary, stackSegmentMove, breakpointMatch, coreException} <= 4'h0;
		srcDrop <= 1'h1;
		@(posedge clock);
		srcDrop <= 1'h0;
		check("valid", 32'(dispatchValid), 32'(v));
		if (v) check("kind", 32'(dispatchKind), 32'(k));
		if (v && k != DK_DEBUG)
			check("vector", 32'(dispatchVector), 32'(e));
	endtask
	task ret;
		returnFromInterrupt <= 1'h1;
		@(posedge clock);
		returnFromInterrupt <= 1'h0;
		@(posedge clock);
	endtask
	function automatic logic acc(input logic [1:0] s, input logic [7:0] v);
		return s == 2'h2 ? v <= 8'h20 : v >= 8'h10 && v <= 8'h20;
	endfunction
	initial begin
		logic [31:0] d, r;
		logic [7:0] v;
		logic [1:0] s;
		void'($urandom(31));
		repeat (20) @(posedge clock);
		resetn <= 1'h1;
		repeat (3) @(posedge clock);
		check("enable", 32'(enableFlag), 32'h0);
		rd(STATUS_OFF, d, r);
		check("status", 32'(d[2:0]), 32'h0);
		rd(8'h0C, d, r);
		check("unmapped", d, 32'h0);
		check("unmappedResp", r, 32'(RESP_SLVERR));
		go(2'h2, 8'h05);
		ex(0, 0, 0);
		go(2'h0, 8'h00);
		ex(1, DK_NMI, NMI_VECTOR);
		go(2'h1, 8'h00);
		ex(0, 0, 0);
		ret;
		ex(1, DK_NMI, NMI_VECTOR);
		ret;
		wr(CTRL_OFF, 32'h0000_00C1);
		gateIsTrap <= 1'h1;
		for (int i = 0; i < 14; i++) begin
			s = 2'h2 + 2'($urandom_range(1));
			v = i == 0 ? 8'h00 : 8'($urandom_range(8'h22, 8'h0E));
			go(s, v);
			ex(acc(s, v), s == 2'h2 ? DK_PIN : DK_LIC, v);
			if (acc(s, v))
				check("errCode", 32'(dispatchErrCode), 32'h0);
		end
		check("trapGate", 32'(enableFlag), 32'h1);
		go(2'h2, NMI_VECTOR);
		ex(1, DK_PIN, NMI_VECTOR);
		go(2'h0, 8'h00);
		ex(1, DK_NMI, NMI_VECTOR);
		ret;
		// nmi wins over a waiting request pin, which is then withdrawn and raised again
		go(2'h2, 8'h07);
		go(2'h0, 8'h00);
		ex(1, DK_NMI, NMI_VECTOR);
		gateIsTrap <= 1'h0;
		go(2'h2, 8'h07);
		ex(1, DK_PIN, 8'h07);
		check("intGate", 32'(enableFlag), 32'h0);
		ret;
		{flagsLoad, flagsLoadIf} <= 2'h3;
		@(posedge clock);
		flagsLoad <= 1'h0;
		@(posedge clock);
		check("reload", 32'({enableFlag, flagsPushBit}), 32'h3);
		for (int i = 0; i < 2; i++) begin
			wr(CTRL_OFF, i ? 32'h0000_00C1 : 32'h0000_0031);
			clearEnableInstr <= 1'h1;
			@(posedge clock);
			clearEnableInstr <= 1'h0;
			@(posedge clock);
			check("clear", 32'(enableFlag), 32'(!i));
		end
		// only the low-privilege clear above may have faulted
		rd(STATUS_OFF, d, r);
		check("gpCount", 32'(d[ST_GPCNT_LSB +: 8]), 32'h1);
		for (int i = 0; i < 2; i++) begin
			wr(CTRL_OFF, i ? 32'h0 : 32'h2);
			breakpointMatch <= 1'h1;
			ex(1'(i), DK_DEBUG, 8'h00);
		end
		{coreExcVector, coreException} <= {8'h0E, 1'h1};
		ex(1, DK_NONE, 8'h0E);
		stackSegmentMove <= 1'h1;
		ex(0, 0, 0);
		go(2'h0, 8'h00);
		ex(0, 0, 0);
		ex(1, DK_NMI, NMI_VECTOR);
		// v86 handler return at low io privilege faults, nmi unblocked
		v86Handler <= 1'h1;
		ret;
		check("gpValid", 32'(dispatchValid), 32'h1);
		check("gpKind", 32'(dispatchKind), 32'(DK_GP));
		v86Handler <= 1'h0;
		go(2'h1, 8'h00);
		ex(1, DK_NMI, NMI_VECTOR);
		stop_test;
	end
endmodule // tb
`default_nettype wire
